// File: rtl/cmv_cfg.svh
`ifndef CMV_CFG_SVH
`define CMV_CFG_SVH

// ----------------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------------
`define CMV_INT_MAJOR 6'h00
`define CMV_PRIV_MINOR 6'h34
`define CMV_SYS_HIGH_SUB 5'h0b
`define CMV_FLT_MAJOR 6'h15
`define CMV_FLT_MINOR 6'h3b
`define CMV_FPU_LOW_SUB 8'ha0
`define CMV_FPU_HIGH_SUB 8'he0
`define CMV_COP2_MAJOR 6'h08
`define CMV_COP2_LOW_SUB 4'h4
`define CMV_COP2_HIGH_SUB 4'hc

// ----------------------------------------------------------------------------
// Architecture revision thresholds
// ----------------------------------------------------------------------------
`define CMV_REV_HIGH_MOVES 4'h2
`define CMV_REV_SILENT_DROP 4'h6

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CMV_OFF_CTRL 8'h00
`define CMV_OFF_STATUS 8'h04
`define CMV_OFF_MASK 8'h08
`define CMV_OFF_COUNT 8'h0c

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define CMV_CTRL_CU0_BIT 0
`define CMV_CTRL_CU1_BIT 1
`define CMV_CTRL_CU2_BIT 2
`define CMV_CTRL_MVH_BIT 3
`define CMV_CTRL_REV_LSB 4
`define CMV_CTRL_WIDTH 8
`define CMV_CTRL_RST 8'h68
`define CMV_MASK_RST 4'h0

// ----------------------------------------------------------------------------
// Event bits of the status and mask registers
// ----------------------------------------------------------------------------
`define CMV_EV_DONE 0
`define CMV_EV_RESERVED 1
`define CMV_EV_UNUSABLE 2
`define CMV_EV_DROPPED 3
`define CMV_EV_NUM 4

`endif

// File: rtl/cmv_pkg.sv
package cmv_pkg;

  typedef enum logic [5:0] {
    CMV_K_NONE = 6'h01,
    CMV_K_FPU_LOW = 6'h02,
    CMV_K_FPU_HIGH = 6'h04,
    CMV_K_SYS_HIGH = 6'h08,
    CMV_K_COP2_LOW = 6'h10,
    CMV_K_COP2_HIGH = 6'h20
  } cmv_kind_t;

  typedef enum logic [1:0] {
    CMV_U_SYS = 2'h0,
    CMV_U_FPU = 2'h1,
    CMV_U_COP2 = 2'h2
  } cmv_unit_t;

endpackage

// File: rtl/cmv_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmv_cfg.svh"

module cmv_decode (
  input wire logic [31:0] instr_word,
  output cmv_pkg::cmv_kind_t kind,
  output logic [11:0] selector
);
  import cmv_pkg::*;

  function automatic logic float_sub(input logic [31:0] w, input logic [7:0] sub);
    float_sub = (w[31:26] == `CMV_FLT_MAJOR) && (w[5:0] == `CMV_FLT_MINOR) &&
                (w[15:14] == 2'h0) && (w[13:6] == sub);
  endfunction

  function automatic logic cop2_sub(input logic [31:0] w, input logic [3:0] sub);
    cop2_sub = (w[31:26] == `CMV_COP2_MAJOR) && (w[15:12] == sub);
  endfunction

  always_comb begin
    kind = CMV_K_NONE;
    selector = 12'h000;
    if (float_sub(instr_word, `CMV_FPU_LOW_SUB)) begin
      kind = CMV_K_FPU_LOW;
      selector = {7'h00, instr_word[20:16]};
    end else if (float_sub(instr_word, `CMV_FPU_HIGH_SUB)) begin
      kind = CMV_K_FPU_HIGH;
      selector = {7'h00, instr_word[20:16]};
    end else if ((instr_word[31:26] == `CMV_INT_MAJOR) && (instr_word[5:0] == `CMV_PRIV_MINOR) &&
                 (instr_word[10:6] == `CMV_SYS_HIGH_SUB) && (instr_word[15:14] == 2'h0)) begin
      kind = CMV_K_SYS_HIGH;
      selector = {4'h0, instr_word[20:16], instr_word[13:11]};
    end else if (cop2_sub(instr_word, `CMV_COP2_LOW_SUB)) begin
      kind = CMV_K_COP2_LOW;
      selector = instr_word[11:0];
    end else if (cop2_sub(instr_word, `CMV_COP2_HIGH_SUB)) begin
      kind = CMV_K_COP2_HIGH;
      selector = instr_word[11:0];
    end
  end

endmodule // cmv_decode
`default_nettype wire

// File: rtl/cmv_irq.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmv_cfg.svh"

module cmv_irq (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [`CMV_EV_NUM-1:0] event_set,
  input wire logic clear_we,
  input wire logic [`CMV_EV_NUM-1:0] clear_bits,
  input wire logic [`CMV_EV_NUM-1:0] mask_bits,
  output logic [`CMV_EV_NUM-1:0] status_q,
  output logic irq
);
  import cmv_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `CMV_EV_NUM; i++) begin : g_flag
      // A set in the same cycle as a write-one clear wins.
      always_ff @(posedge mclk) begin
        if (srst) begin
          status_q[i] <= 1'b0;
        end else if (event_set[i]) begin
          status_q[i] <= 1'b1;
        end else if (clear_we && clear_bits[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(status_q & mask_bits);

endmodule // cmv_irq
`default_nettype wire

// File: rtl/cmv_move_unit.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cmv_cfg.svh"

module cmv_move_unit (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] gpr_rdata,
  input wire logic priv_kernel,
  input wire logic sysctrl_ext_ok,
  output logic cop_wr_stb,
  output cmv_pkg::cmv_unit_t cop_wr_unit,
  output logic [11:0] cop_wr_sel,
  output logic [31:0] cop_wr_data,
  output logic cop_wr_high,
  output logic cop_wr_upper_undef,
  output logic exc_stb,
  output logic exc_reserved,
  output logic exc_cop_unusable,
  output cmv_pkg::cmv_unit_t exc_cop_num
);
  import cmv_pkg::*;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  cmv_kind_t kind;
  logic [11:0] selector;
  logic [`CMV_CTRL_WIDTH-1:0] ctrl_q;
  logic [`CMV_EV_NUM-1:0] mask_q;
  logic [`CMV_EV_NUM-1:0] status_q;
  logic [`CMV_EV_NUM-1:0] event_set;
  logic [15:0] count_q;
  logic [3:0] rev;
  logic move_high_capability;
  cmv_unit_t unit;
  logic is_move;
  logic is_high;
  logic unit_ok;
  logic take_unusable;
  logic take_reserved;
  logic take_drop;
  logic take_write;
  logic apb_setup;
  logic apb_access;
  logic apb_hit;
  logic [31:0] rd_d;

  cmv_decode u_decode (
    .instr_word(instr_word),
    .kind(kind),
    .selector(selector)
  );

  assign rev = ctrl_q[`CMV_CTRL_REV_LSB +: 4];
  assign move_high_capability = ctrl_q[`CMV_CTRL_MVH_BIT];
  assign is_move = instr_valid && (kind != CMV_K_NONE);
  assign is_high = (kind == CMV_K_FPU_HIGH) || (kind == CMV_K_SYS_HIGH) || (kind == CMV_K_COP2_HIGH);

  always_comb begin
    case (kind)
      CMV_K_FPU_LOW, CMV_K_FPU_HIGH: begin
        unit = CMV_U_FPU;
      end
      CMV_K_COP2_LOW, CMV_K_COP2_HIGH: begin
        unit = CMV_U_COP2;
      end
      default: begin
        unit = CMV_U_SYS;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Exception checks
  // --------------------------------------------------------------------------
  // access enables
  always_comb begin
    case (unit)
      CMV_U_FPU: begin
        unit_ok = ctrl_q[`CMV_CTRL_CU1_BIT];
      end
      CMV_U_COP2: begin
        unit_ok = ctrl_q[`CMV_CTRL_CU2_BIT];
      end
      default: begin
        unit_ok = priv_kernel || ctrl_q[`CMV_CTRL_CU0_BIT];
      end
    endcase
  end

  assign take_unusable = is_move && !unit_ok;

  assign take_reserved = is_move && unit_ok &&
                         (((kind == CMV_K_SYS_HIGH) && !move_high_capability) ||
                          (((kind == CMV_K_FPU_HIGH) || (kind == CMV_K_COP2_HIGH)) &&
                           (rev < `CMV_REV_HIGH_MOVES)));

  assign take_drop = is_move && unit_ok && !take_reserved && (kind == CMV_K_SYS_HIGH) &&
                     (rev >= `CMV_REV_SILENT_DROP) && !sysctrl_ext_ok;

  assign take_write = is_move && !take_unusable && !take_reserved && !take_drop;

  // --------------------------------------------------------------------------
  // Coprocessor write port
  // --------------------------------------------------------------------------
  // write strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      cop_wr_stb <= 1'b0;
    end else begin
      cop_wr_stb <= take_write;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cop_wr_unit <= CMV_U_SYS;
      cop_wr_sel <= 12'h000;
      cop_wr_data <= 32'h0000_0000;
      cop_wr_high <= 1'b0;
    end else if (take_write) begin
      cop_wr_unit <= unit;
      cop_wr_sel <= selector;
      cop_wr_data <= gpr_rdata;
      cop_wr_high <= is_high;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cop_wr_upper_undef <= 1'b0;
    end else if (take_write) begin
      cop_wr_upper_undef <= (kind == CMV_K_FPU_LOW) || (kind == CMV_K_COP2_LOW);
    end
  end

  // --------------------------------------------------------------------------
  // Exception reporting
  // --------------------------------------------------------------------------
  // exception pulses
  always_ff @(posedge mclk) begin
    if (srst) begin
      exc_stb <= 1'b0;
      exc_reserved <= 1'b0;
      exc_cop_unusable <= 1'b0;
      exc_cop_num <= CMV_U_SYS;
    end else begin
      exc_stb <= take_unusable || take_reserved;
      exc_reserved <= take_reserved;
      exc_cop_unusable <= take_unusable;
      exc_cop_num <= take_unusable ? unit : CMV_U_SYS;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      count_q <= 16'h0000;
    end else if (take_write) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_hit = (paddr == `CMV_OFF_CTRL) || (paddr == `CMV_OFF_STATUS) ||
                   (paddr == `CMV_OFF_MASK) || (paddr == `CMV_OFF_COUNT);
  assign pready = 1'b1;
  assign pslverr = apb_access && !apb_hit;

  always_comb begin
    case (paddr)
      `CMV_OFF_CTRL: begin
        rd_d = {24'h000000, ctrl_q};
      end
      `CMV_OFF_STATUS: begin
        rd_d = {28'h0000000, status_q};
      end
      `CMV_OFF_MASK: begin
        rd_d = {28'h0000000, mask_q};
      end
      `CMV_OFF_COUNT: begin
        rd_d = {16'h0000, count_q};
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured in the setup cycle so it stands in the access cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= `CMV_CTRL_RST;
    end else if (apb_access && pwrite && (paddr == `CMV_OFF_CTRL)) begin
      ctrl_q <= pwdata[`CMV_CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_q <= `CMV_MASK_RST;
    end else if (apb_access && pwrite && (paddr == `CMV_OFF_MASK)) begin
      mask_q <= pwdata[`CMV_EV_NUM-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  always_comb begin
    event_set = '0;
    event_set[`CMV_EV_DONE] = cop_wr_stb;
    event_set[`CMV_EV_RESERVED] = exc_reserved;
    event_set[`CMV_EV_UNUSABLE] = exc_cop_unusable;
    event_set[`CMV_EV_DROPPED] = take_drop;
  end

  cmv_irq u_irq (
    .mclk(mclk),
    .srst(srst),
    .event_set(event_set),
    .clear_we(apb_access && pwrite && (paddr == `CMV_OFF_STATUS)),
    .clear_bits(pwdata[`CMV_EV_NUM-1:0]),
    .mask_bits(mask_q),
    .status_q(status_q),
    .irq(irq)
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence s_fpu_high_ok;
    is_move && (kind == CMV_K_FPU_HIGH) && ctrl_q[`CMV_CTRL_CU1_BIT] && (rev >= `CMV_REV_HIGH_MOVES);
  endsequence

  sequence s_sys_high_ok;
    is_move && (kind == CMV_K_SYS_HIGH) && unit_ok && move_high_capability;
  endsequence

  sequence s_cop2_ok(logic [5:0] k);
    is_move && (kind == k) && ctrl_q[`CMV_CTRL_CU2_BIT];
  endsequence

  low_fpu_undef_a: assert property (
    (is_move && (kind == CMV_K_FPU_LOW) && ctrl_q[`CMV_CTRL_CU1_BIT]) |=>
      (cop_wr_stb && cop_wr_upper_undef && !cop_wr_high && (cop_wr_unit == CMV_U_FPU)))
    else $error("low fpu move did not flag upper half undefined");

  cop2_low_word_a: assert property (
    s_cop2_ok(CMV_K_COP2_LOW) |=> (cop_wr_stb && !cop_wr_high && (cop_wr_data == $past(gpr_rdata))))
    else $error("low cop-two move lost its data");

  cop2_sel_pass_a: assert property (
    (cop_wr_stb && (cop_wr_unit == CMV_U_COP2)) |-> (cop_wr_sel == $past(instr_word[11:0])))
    else $error("cop-two selector altered");

  sys_high_write_a: assert property (
    (s_sys_high_ok ##0 (sysctrl_ext_ok || (rev < `CMV_REV_SILENT_DROP))) |=>
      (cop_wr_stb && cop_wr_high && (cop_wr_unit == CMV_U_SYS) && (cop_wr_data == $past(gpr_rdata)) &&
       (cop_wr_sel == {4'h0, $past(instr_word[20:16]), $past(instr_word[13:11])})))
    else $error("sysctrl high move wrote wrong register");

  sys_drop_r6_a: assert property (
    (s_sys_high_ok ##0 (!sysctrl_ext_ok && (rev >= `CMV_REV_SILENT_DROP))) |=>
      (!cop_wr_stb && !exc_stb && status_q[`CMV_EV_DROPPED]))
    else $error("revision six write to non-extended register not dropped");

  sys_old_rev_a: assert property (
    (s_sys_high_ok ##0 (rev < `CMV_REV_SILENT_DROP)) |=> cop_wr_stb)
    else $error("older revision sysctrl high move not forwarded");

  fpu_high_write_a: assert property (
    s_fpu_high_ok |=> (cop_wr_stb && cop_wr_high && !cop_wr_upper_undef &&
                       (cop_wr_data == $past(gpr_rdata)) && (cop_wr_sel[4:0] == $past(instr_word[20:16]))))
    else $error("high fpu move wrong");

  old_rev_reserved_a: assert property (
    (is_move && unit_ok && ((kind == CMV_K_FPU_HIGH) || (kind == CMV_K_COP2_HIGH)) &&
     (rev < `CMV_REV_HIGH_MOVES)) |=> (exc_reserved && exc_stb && !cop_wr_stb))
    else $error("old revision high move not reserved");

  cop2_high_write_a: assert property (
    (s_cop2_ok(CMV_K_COP2_HIGH) ##0 (rev >= `CMV_REV_HIGH_MOVES)) |=>
      (cop_wr_stb && cop_wr_high && !cop_wr_upper_undef))
    else $error("high cop-two move wrong");

  mvh_reserved_a: assert property (
    (is_move && (kind == CMV_K_SYS_HIGH) && unit_ok && !move_high_capability) |=> (exc_reserved && !cop_wr_stb))
    else $error("sysctrl high move without capability not reserved");

  unusable_block_a: assert property (
    (is_move && !unit_ok) |=> (exc_cop_unusable && !cop_wr_stb && (exc_cop_num == $past(unit)))
      ##1 status_q[`CMV_EV_UNUSABLE])
    else $error("disabled coprocessor not reported");

  strobe_only_move_a: assert property (
    cop_wr_stb |-> $past(is_move))
    else $error("write strobe without move");

endmodule // cmv_move_unit
`default_nettype wire

// File: testbench/cmv_cop_model.sv
`timescale 1ns/10ps
`default_nettype none

module cmv_cop_model (
  input wire logic mclk,
  input wire logic cop_wr_stb,
  input wire cmv_pkg::cmv_unit_t cop_wr_unit,
  input wire logic [11:0] cop_wr_sel,
  input wire logic [31:0] cop_wr_data,
  input wire logic cop_wr_high,
  input wire logic cop_wr_upper_undef,
  input wire logic [7:0] sys_query,
  output logic ext_ok,
  input wire logic [1:0] rd_unit,
  input wire logic [11:0] rd_sel,
  output logic [63:0] rd_val
);
  import cmv_pkg::*;
  logic [63:0] regs_q [1024];
  logic [9:0] idx;

  // Only odd system-control register numbers are 64 bits wide.
  // extension table
  assign ext_ok = sys_query[3];
  assign idx = {cop_wr_unit, cop_wr_sel[7:0]};
  assign rd_val = regs_q[{rd_unit, rd_sel[7:0]}];

  always_ff @(posedge mclk) begin
    if (cop_wr_stb && cop_wr_high) begin
      regs_q[idx][63:32] <= cop_wr_data;
    end else if (cop_wr_stb) begin
      regs_q[idx][31:0] <= cop_wr_data;
      if (cop_wr_upper_undef) begin
        regs_q[idx][63:32] <= ~regs_q[idx][63:32];
      end
    end
  end
endmodule // cmv_cop_model

`default_nettype wire

// File: testbench/coprocessor_move_to_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmv_cfg.svh"

module coprocessor_move_to_unit_tb;
  import cmv_pkg::*;
  typedef struct {
    logic [31:0] w;
    logic [31:0] g;
    logic stb;
    logic [1:0] u;
    logic [11:0] s;
    logic hi;
    logic un;
    logic [2:0] ex;
    logic [1:0] num;
  } cmv_row_t;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, irq, instr_valid, priv_kernel, sysctrl_ext_ok;
  logic cop_wr_stb, cop_wr_high, cop_wr_upper_undef, exc_stb, exc_reserved, exc_cop_unusable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, instr_word, gpr_rdata, cop_wr_data;
  logic [11:0] cop_wr_sel, rd_sel;
  logic [1:0] rd_unit;
  logic [63:0] rd_val;
  cmv_unit_t cop_wr_unit, exc_cop_num;
  int mismatches, total_checks, nwr;
  cmv_row_t rows [8];

  cmv_move_unit DUT (.mclk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .instr_valid, .instr_word, .gpr_rdata, .priv_kernel, .sysctrl_ext_ok, .cop_wr_stb, .cop_wr_unit, .cop_wr_sel,
    .cop_wr_data, .cop_wr_high, .cop_wr_upper_undef, .exc_stb, .exc_reserved, .exc_cop_unusable, .exc_cop_num);
  cmv_cop_model far_side (.mclk, .cop_wr_stb, .cop_wr_unit, .cop_wr_sel, .cop_wr_data, .cop_wr_high,
    .cop_wr_upper_undef, .sys_query({instr_word[20:16], instr_word[13:11]}), .ext_ok(sysctrl_ext_ok), .rd_unit,
    .rd_sel, .rd_val);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----
  // Helpers
  // ----
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, er, input logic ee);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n < 20) begin
      check(pslverr, ee);
      if (!w) check(prdata, er);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      mismatches++;
      $display("mismatch at %0t: bus answer timed out", $time);
      stop_test();
    end
  endtask

  // Offers one instruction and checks what appears one edge later.
  task automatic run_row(input cmv_row_t r);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= r.w;
    gpr_rdata <= r.g;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    check(cop_wr_stb, r.stb);
    check({exc_stb, exc_reserved, exc_cop_unusable, exc_cop_num}, {r.ex, r.num});
    if (r.stb) begin
      check({cop_wr_unit, cop_wr_sel, cop_wr_data, cop_wr_high, cop_wr_upper_undef}, {r.u, r.s, r.g, r.hi, r.un});
      nwr++;
    end
  endtask

  task automatic peek(input logic [1:0] u, input logic [11:0] s, input logic [63:0] exp, msk);
    rd_unit = u;
    rd_sel = s;
    #1;
    check(rd_val & msk, exp);
  endtask

  function automatic cmv_row_t mk(input logic [31:0] w, g, input logic stb, input logic [1:0] u,
    input logic [11:0] s, input logic hi, un, input logic [2:0] ex, input logic [1:0] num);
    mk = '{w, g, stb, u, s, hi, un, ex, num};
  endfunction

  function automatic logic [31:0] fmv(input logic [7:0] sub, input logic [4:0] fs);
    return {6'h15, 5'd2, fs, 2'b00, sub, 6'h3b};
  endfunction

  function automatic logic [31:0] shi(input logic [4:0] rs, input logic [2:0] sel);
    return {6'h00, 5'd2, rs, 2'b00, sel, 5'h0b, 6'h34};
  endfunction

  function automatic logic [31:0] c2(input logic [3:0] sub, input logic [11:0] impl);
    return {`CMV_COP2_MAJOR, 5'd2, 5'd0, sub, impl};
  endfunction

  // ----
  // Main sequence
  // ----
  initial begin
    {srst, psel, penable, pwrite, instr_valid, priv_kernel} = 6'h20;
    {paddr, pwdata, instr_word, gpr_rdata, rd_unit, rd_sel} = '0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    apb(0, `CMV_OFF_CTRL, 0, 32'h68, 0);
    apb(0, `CMV_OFF_STATUS, 0, 0, 0);
    apb(0, `CMV_OFF_MASK, 0, 0, 0);
    check({irq, cop_wr_stb, exc_stb}, 3'h0);
    apb(1, `CMV_OFF_CTRL, 32'h6f, 0, 0);
    rows[0] = mk(fmv(8'ha0, 3), 32'ha5a5_0001, 1, 1, 12'h003, 0, 1, 0, 0);
    rows[1] = mk(fmv(8'he0, 3), 32'h1234_5678, 1, 1, 12'h003, 1, 0, 0, 0);
    rows[2] = mk(shi(5, 2), 32'hcafe_0005, 1, 0, {4'h0, 5'd5, 3'd2}, 1, 0, 0, 0);
    rows[3] = mk(shi(4, 0), 32'h0bad_0004, 0, 0, 0, 0, 0, 0, 0);
    rows[4] = mk(c2(4'h4, 12'hf3c), 32'h0000_c0de, 1, 2, 12'hf3c, 0, 1, 0, 0);
    rows[5] = mk(c2(4'hc, 12'hf3c), 32'hbeef_0000, 1, 2, 12'hf3c, 1, 0, 0, 0);
    rows[6] = mk(32'h0, 32'h1, 0, 0, 0, 0, 0, 0, 0);
    rows[7] = mk(fmv(8'he0, 3) ^ 32'h1, 32'h1, 0, 0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 8; i++) run_row(rows[i]);
    peek(1, 3, 64'h1234_5678_a5a5_0001, '1);
    peek(2, 12'hf3c, 64'hbeef_0000_0000_c0de, '1);
    peek(0, 12'h02a, 64'hcafe_0005_0000_0000, 64'hffff_ffff_0000_0000);
    // Disabled units, missing capability and an old revision.
    apb(1, `CMV_OFF_CTRL, 32'h6d, 0, 0);
    run_row(mk(fmv(8'he0, 3), 32'h5, 0, 0, 0, 0, 0, 3'b101, 1));
    apb(1, `CMV_OFF_CTRL, 32'h6b, 0, 0);
    run_row(mk(c2(4'hc, 12'h001), 32'h5, 0, 0, 0, 0, 0, 3'b101, 2));
    apb(1, `CMV_OFF_CTRL, 32'h6e, 0, 0);
    run_row(mk(shi(7, 1), 32'h7, 0, 0, 0, 0, 0, 3'b101, 0));
    @(posedge mclk) priv_kernel <= 1'b1;
    run_row(mk(shi(7, 1), 32'h7, 1, 0, {4'h0, 5'd7, 3'd1}, 1, 0, 0, 0));
    apb(1, `CMV_OFF_CTRL, 32'h67, 0, 0);
    run_row(mk(shi(7, 1), 32'h7, 0, 0, 0, 0, 0, 3'b110, 0));
    apb(1, `CMV_OFF_CTRL, 32'h1f, 0, 0);
    run_row(mk(fmv(8'he0, 4), 32'h9, 0, 0, 0, 0, 0, 3'b110, 0));
    run_row(mk(c2(4'hc, 12'h002), 32'h9, 0, 0, 0, 0, 0, 3'b110, 0));
    run_row(mk(fmv(8'ha0, 4), 32'h9, 1, 1, 12'h004, 0, 1, 0, 0));
    run_row(mk(shi(4, 0), 32'h9, 1, 0, {4'h0, 5'd4, 3'd0}, 1, 0, 0, 0));
    apb(1, `CMV_OFF_CTRL, 32'h1d, 0, 0);
    run_row(mk(fmv(8'he0, 4), 32'h9, 0, 0, 0, 0, 0, 3'b101, 1));
    // Low then high move on consecutive cycles.
    apb(1, `CMV_OFF_CTRL, 32'h6f, 0, 0);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_word <= fmv(8'ha0, 7);
    gpr_rdata <= 32'h7777_0000;
    @(posedge mclk);
    instr_word <= fmv(8'he0, 7);
    gpr_rdata <= 32'h8888_0000;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    check({cop_wr_stb, cop_wr_high, cop_wr_data}, {2'b11, 32'h8888_0000});
    nwr += 2;
    // The far side stores the high word one edge after its strobe.
    @(posedge mclk);
    peek(1, 7, 64'h8888_0000_7777_0000, '1);
    // Events, mask and counter.
    apb(0, `CMV_OFF_STATUS, 0, 32'hf, 0);
    check(irq, 1'b0);
    apb(1, `CMV_OFF_MASK, 32'h4, 0, 0);
    #1 check(irq, 1'b1);
    apb(0, `CMV_OFF_MASK, 0, 32'h4, 0);
    apb(1, `CMV_OFF_STATUS, 32'h4, 0, 0);
    #1 check(irq, 1'b0);
    apb(0, `CMV_OFF_STATUS, 0, 32'hb, 0);
    apb(1, `CMV_OFF_COUNT, 32'hffff, 0, 0);
    apb(0, `CMV_OFF_COUNT, 0, nwr, 0);
    apb(0, 8'h10, 0, 0, 1);
    apb(1, 8'h10, 32'h1, 0, 1);
    // Second reset in mid-run.
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    apb(0, `CMV_OFF_CTRL, 0, 32'h68, 0);
    apb(0, `CMV_OFF_COUNT, 0, 0, 0);
    check(irq, 1'b0);
    stop_test();
  end
endmodule // coprocessor_move_to_unit_tb

`default_nettype wire
